// >>> sarseq_map.svh
// Purpose: Addresses, field positions, reset values and timing counts of the converter sequencer.
// Assumes: Included by bare name; definitions only.
// Notes:   Times are counts of peripheral clock cycles (I_CLK).
`ifndef SARSEQ_MAP_SVH
`define SARSEQ_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define SARSEQ_ADDR_MODE      16'hFF2A
`define SARSEQ_ADDR_RESULT    16'hFF18
`define SARSEQ_ADDR_RESULT_HI 16'hFF1F
`define SARSEQ_ADDR_PINCFG    16'hFF2C
`define SARSEQ_ADDR_CHSEL     16'hFF2D

// ****************************************
// Mode register fields and reset values
// ****************************************
`define SARSEQ_MODE_RESET     8'h00
`define SARSEQ_MODE_RUN       7
`define SARSEQ_MODE_FIXED0    6
`define SARSEQ_MODE_TSEL_MSB  5
`define SARSEQ_MODE_TSEL_LSB  3
`define SARSEQ_MODE_REF_MSB   2
`define SARSEQ_MODE_REF_LSB   1
`define SARSEQ_MODE_CMP       0
`define SARSEQ_PINCFG_RESET   5'h10
`define SARSEQ_CHSEL_RESET    4'h0
`define SARSEQ_RESULT_RESET   10'h000
`define SARSEQ_LOW_ZERO       6'h00

// ****************************************
// Timing: 12 sample steps plus 10 bit steps; fastest code 7 plus 10 of 3
// ****************************************
`define SARSEQ_SAMPLE_STEPS   4'hC
`define SARSEQ_RES_BITS       4'hA
`define SARSEQ_MSB_TRIAL      10'h200
`define SARSEQ_CONV_CYC_0     9'h108
`define SARSEQ_CONV_CYC_1     9'h0B0
`define SARSEQ_CONV_CYC_2     9'h084
`define SARSEQ_CONV_CYC_3     9'h058
`define SARSEQ_CONV_CYC_4     9'h042
`define SARSEQ_CONV_CYC_5     9'h02C
`define SARSEQ_DIV_0          4'hC
`define SARSEQ_DIV_1          4'h8
`define SARSEQ_DIV_2          4'h6
`define SARSEQ_DIV_3          4'h4
`define SARSEQ_DIV_4          4'h3
`define SARSEQ_DIV_5          4'h2
`define SARSEQ_MIN_BIT_STEP   4'h3
`define SARSEQ_FAST_SAMPLE_STEPS 4'h7

`endif

// >>> sarseq_pkg.sv
// Purpose: Types shared by the converter sequencer modules.
// Assumes: Constants live in sarseq_map.svh.
// Notes:   Each sequencer module keeps its design state in one packed struct.
package sarseq_pkg;

    typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_SAMPLE, ST_CONVERT} sarseq_state_t;

    typedef struct packed {
        logic [7:0]    mode;
        logic [4:0]    pincfg;
        logic [3:0]    chsel;
        logic [9:0]    result;
        logic [7:0]    result_hi;
        sarseq_state_t state;
        logic [3:0]    step_cnt;
        logic [3:0]    phase;
        logic          irq;
        logic          rd_wait;
        logic          rd_hi;
        logic          rd_valid;
        logic [15:0]   rd_data;
    } sarseq_top_st_t;

    typedef struct packed {
        logic [9:0] approx;
        logic [3:0] bit_idx;
        logic       active;
        logic       done;
    } sarseq_sar_st_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } sarseq_sync_st_t;

endpackage

// >>> sarseq_sync.sv
// Purpose: Two-stage synchroniser for the comparator decision.
// Assumes: Input is asynchronous to i_clk.
// Notes:   Only s2 is read outside.
`timescale 1ns/1ps
module sarseq_sync (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_d,
    output logic      o_q
);
    sarseq_pkg::sarseq_sync_st_t st_r;
    sarseq_pkg::sarseq_sync_st_t st_nxt;

    // Shift chain
    always_comb begin
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_q = st_r.s2;
endmodule

// >>> sarseq_sar.sv
// Purpose: Approximation register, resolves 10 bits MSB first.
// Assumes: i_start and i_decide are single-cycle pulses, never together.
// Notes:   o_code is the trial word driven to the ladder.
`timescale 1ns/1ps
`include "sarseq_map.svh"
module sarseq_sar (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_start,
    input  wire logic       i_decide,
    input  wire logic       i_cmp,
    output logic [9:0]      o_code,
    output logic            o_done
);
    sarseq_pkg::sarseq_sar_st_t st_r;
    sarseq_pkg::sarseq_sar_st_t st_nxt;

    // One-hot weight of a bit position
    function automatic logic [9:0] weight(input logic [3:0] idx);
        weight = 10'(10'h001 << idx);
    endfunction

    // Trial bit kept when the held input is at or above the ladder
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (i_start) begin
            st_nxt.approx  = `SARSEQ_MSB_TRIAL;
            st_nxt.bit_idx = `SARSEQ_RES_BITS - 4'h1;
            st_nxt.active  = 1'b1;
        end else if (i_decide && st_r.active) begin
            if (!i_cmp) begin
                st_nxt.approx = st_r.approx & ~weight(st_r.bit_idx);
            end
            if (st_r.bit_idx == 4'h0) begin
                st_nxt.active = 1'b0;
                st_nxt.done   = 1'b1;
            end else begin
                st_nxt.approx  = (i_cmp ? st_r.approx : (st_r.approx & ~weight(st_r.bit_idx)))
                                 | weight(4'(st_r.bit_idx - 4'h1));
                st_nxt.bit_idx = 4'(st_r.bit_idx - 4'h1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_code = st_r.approx;
    assign o_done = st_r.done;

    chk_msb_first: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_start |=> o_code == `SARSEQ_MSB_TRIAL) else $error("first trial is not the top bit");
    chk_lsb_last: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_done |-> $past(st_r.bit_idx) == 4'h0 && !st_r.active) else $error("done before last bit");
endmodule

// >>> sarseq_top.sv
// Purpose: Control logic of a 10-bit successive-approximation converter, 16 inputs.
// Assumes: I_CLK is the peripheral clock; I_CMP comes from the analog comparator.
// Notes:   Registers sit on a byte/bit write and 16-bit read port with wait cycles.
// How it works
// - Repeat 10-bit conversions on one channel while running
// - Pulse done interrupt after each conversion
// - Sixteen inputs, ten-bit resolution each
// - Sample at start, hold through conversion
// - Resolve bits MSB first to LSB
// - Copy approximation into results after LSB
// - Result word left aligned, low six zero
// - High byte updated every completion
// - Result reads insert one wait cycle
// - Pin config selects analog or digital
// - Channel select picks sampled input
// - Mode register at FF2A, resets 00
// - Mode register takes bit and byte writes
// - Bit 7 runs or stops conversion
// - Bit 0 powers the comparator
// - Bit 6 zero, time and range fields
// - Stop, wait or convert by two bits
// - Time codes give 264 to 44 cycles
`timescale 1ns/1ps
`include "sarseq_map.svh"
module sarseq_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic [15:0] I_ADDR,
    input  wire logic        I_WR,
    input  wire logic        I_BIT_WR,
    input  wire logic [2:0]  I_BIT_POS,
    input  wire logic        I_BIT_VAL,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_RD,
    output logic [15:0]      O_RDATA,
    output logic             O_RD_VALID,
    output logic             O_WAIT,
    input  wire logic        I_CMP,
    output logic             O_CMP_EN,
    output logic             O_SAMPLE,
    output logic [9:0]       O_LADDER_CODE,
    output logic [1:0]       O_REF_RANGE,
    output logic [3:0]       O_CH_SEL,
    output logic [15:0]      O_PIN_ANALOG,
    output logic             O_IRQ
);
    // ****************************************
    // Declarations
    // ****************************************
    sarseq_pkg::sarseq_top_st_t st_r;
    sarseq_pkg::sarseq_top_st_t st_nxt;
    logic                       cmp_sync;
    logic                       sar_start;
    logic                       sar_decide;
    logic                       sar_done;
    logic [9:0]                 sar_code;
    logic                       run;
    logic                       tick;
    logic [2:0]                 tsel;
    logic [3:0]                 div;
    logic                       fast;
    logic [3:0]                 step_len;
    logic [3:0]                 last_sample;

    // ****************************************
    // Decoders
    // ****************************************
    // Step length per bit; prohibited codes fall back to the slowest
    function automatic logic [3:0] step_div(input logic [2:0] sel);
        unique case (sel)
            3'h1:    step_div = `SARSEQ_DIV_1;
            3'h2:    step_div = `SARSEQ_DIV_2;
            3'h3:    step_div = `SARSEQ_DIV_3;
            3'h4:    step_div = `SARSEQ_DIV_4;
            3'h5:    step_div = `SARSEQ_DIV_5;
            default: step_div = `SARSEQ_DIV_0;
        endcase
    endfunction

    // Whole conversion length, used by the timing check
    function automatic logic [8:0] conv_cycles(input logic [2:0] sel);
        unique case (sel)
            3'h1:    conv_cycles = `SARSEQ_CONV_CYC_1;
            3'h2:    conv_cycles = `SARSEQ_CONV_CYC_2;
            3'h3:    conv_cycles = `SARSEQ_CONV_CYC_3;
            3'h4:    conv_cycles = `SARSEQ_CONV_CYC_4;
            3'h5:    conv_cycles = `SARSEQ_CONV_CYC_5;
            default: conv_cycles = `SARSEQ_CONV_CYC_0;
        endcase
    endfunction

    // Byte view of a writable register, base of a bit write
    function automatic logic [7:0] byte_view(input sarseq_pkg::sarseq_top_st_t s, input logic [15:0] a);
        if (a == `SARSEQ_ADDR_MODE) begin
            byte_view = s.mode;
        end else if (a == `SARSEQ_ADDR_PINCFG) begin
            byte_view = {3'h0, s.pincfg};
        end else if (a == `SARSEQ_ADDR_CHSEL) begin
            byte_view = {4'h0, s.chsel};
        end else begin
            byte_view = 8'h00;
        end
    endfunction

    function automatic logic is_result(input logic [15:0] a);
        is_result = (a == `SARSEQ_ADDR_RESULT) || (a == `SARSEQ_ADDR_RESULT_HI);
    endfunction

    // ****************************************
    // Submodules
    // ****************************************
    // Comparator decision crosses in from the analog side
    sarseq_sync u_cmp_sync (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .i_d    (I_CMP),
        .o_q    (cmp_sync)
    );

    sarseq_sar u_sar (
        .i_clk    (I_CLK),
        .i_rstn   (I_RSTN),
        .i_start  (sar_start),
        .i_decide (sar_decide),
        .i_cmp    (cmp_sync),
        .o_code   (sar_code),
        .o_done   (sar_done)
    );

    // ****************************************
    // Sequencer and register file
    // ****************************************
    assign run         = st_r.mode[`SARSEQ_MODE_RUN];
    assign tsel        = st_r.mode[`SARSEQ_MODE_TSEL_MSB:`SARSEQ_MODE_TSEL_LSB];
    assign div         = step_div(tsel);
    // Two-cycle bit steps are shorter than the synchroniser delay, so the
    // fastest code stretches bit steps to 3 and gives the cycles back in sampling
    assign fast        = (div < `SARSEQ_MIN_BIT_STEP);
    assign step_len    = (fast && st_r.state == sarseq_pkg::ST_CONVERT) ? `SARSEQ_MIN_BIT_STEP : div;
    assign last_sample = fast ? 4'(`SARSEQ_FAST_SAMPLE_STEPS - 4'h1) : 4'(`SARSEQ_SAMPLE_STEPS - 4'h1);
    assign tick        = (st_r.step_cnt == 4'(step_len - 4'h1));

    // Step pulses to the approximation register
    always_comb begin
        sar_start  = run && (st_r.state == sarseq_pkg::ST_SAMPLE) && tick
                     && (st_r.phase == last_sample);
        sar_decide = run && (st_r.state == sarseq_pkg::ST_CONVERT) && tick;
    end

    // All next-state logic of the block
    always_comb begin
        logic [7:0] wv;
        wv              = 8'h00;
        st_nxt          = st_r;
        st_nxt.irq      = 1'b0;
        st_nxt.rd_valid = 1'b0;

        // Byte writes, or bit writes merged onto the current byte
        if (I_WR || I_BIT_WR) begin
            wv = byte_view(st_r, I_ADDR);
            if (I_WR) begin
                wv = I_WDATA;
            end else begin
                wv[I_BIT_POS] = I_BIT_VAL;
            end
            if (I_ADDR == `SARSEQ_ADDR_MODE) begin
                st_nxt.mode = wv;
                st_nxt.mode[`SARSEQ_MODE_FIXED0] = 1'b0;
            end else if (I_ADDR == `SARSEQ_ADDR_PINCFG) begin
                st_nxt.pincfg = wv[4:0];
            end else if (I_ADDR == `SARSEQ_ADDR_CHSEL) begin
                st_nxt.chsel = wv[3:0];
            end
        end

        // Stop / wait / sample / convert; run bit rules everything
        unique case (st_r.state)
            sarseq_pkg::ST_STOP, sarseq_pkg::ST_WAIT: begin
                st_nxt.step_cnt = 4'h0;
                st_nxt.phase    = 4'h0;
                if (run) begin
                    st_nxt.state = sarseq_pkg::ST_SAMPLE;
                end else if (st_r.mode[`SARSEQ_MODE_CMP]) begin
                    st_nxt.state = sarseq_pkg::ST_WAIT;
                end else begin
                    st_nxt.state = sarseq_pkg::ST_STOP;
                end
            end
            sarseq_pkg::ST_SAMPLE, sarseq_pkg::ST_CONVERT: begin
                if (!run) begin
                    // Abort: nothing is transferred, no interrupt
                    st_nxt.state    = st_r.mode[`SARSEQ_MODE_CMP] ? sarseq_pkg::ST_WAIT
                                                                 : sarseq_pkg::ST_STOP;
                    st_nxt.step_cnt = 4'h0;
                    st_nxt.phase    = 4'h0;
                end else if (tick) begin
                    st_nxt.step_cnt = 4'h0;
                    st_nxt.phase    = 4'(st_r.phase + 4'h1);
                    if (st_r.state == sarseq_pkg::ST_SAMPLE
                        && st_r.phase == last_sample) begin
                        st_nxt.state = sarseq_pkg::ST_CONVERT;
                        st_nxt.phase = 4'h0;
                    end else if (st_r.state == sarseq_pkg::ST_CONVERT
                                 && st_r.phase == 4'(`SARSEQ_RES_BITS - 4'h1)) begin
                        st_nxt.state = sarseq_pkg::ST_SAMPLE;
                        st_nxt.phase = 4'h0;
                    end
                end else begin
                    st_nxt.step_cnt = 4'(st_r.step_cnt + 4'h1);
                end
            end
        endcase

        // Transfer after the last bit; a late done after abort is dropped
        if (sar_done && run) begin
            st_nxt.result    = sar_code;
            st_nxt.result_hi = sar_code[9:2];
            st_nxt.irq       = 1'b1;
        end

        // Reads: result registers take one wait cycle, others answer at once
        if (st_r.rd_wait) begin
            st_nxt.rd_wait  = 1'b0;
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data  = st_r.rd_hi ? {8'h00, st_r.result_hi}
                                         : {st_r.result, `SARSEQ_LOW_ZERO};
        end else if (I_RD) begin
            if (is_result(I_ADDR)) begin
                st_nxt.rd_wait = 1'b1;
                st_nxt.rd_hi   = (I_ADDR == `SARSEQ_ADDR_RESULT_HI);
            end else begin
                st_nxt.rd_valid = 1'b1;
                st_nxt.rd_data  = {8'h00, byte_view(st_r, I_ADDR)};
            end
        end
    end

    // Single state register; reset values are constants only
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_r           <= '0;
            st_r.mode      <= `SARSEQ_MODE_RESET;
            st_r.pincfg    <= `SARSEQ_PINCFG_RESET;
            st_r.chsel     <= `SARSEQ_CHSEL_RESET;
            st_r.result    <= `SARSEQ_RESULT_RESET;
            st_r.state     <= sarseq_pkg::ST_STOP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Pins at or above the configured count stay digital port pins
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
            assign O_PIN_ANALOG[gi] = (st_r.pincfg > 5'(gi));
        end
    endgenerate

    assign O_CH_SEL      = st_r.chsel;
    assign O_SAMPLE      = (st_r.state == sarseq_pkg::ST_SAMPLE);
    assign O_CMP_EN      = st_r.mode[`SARSEQ_MODE_CMP];
    assign O_REF_RANGE   = st_r.mode[`SARSEQ_MODE_REF_MSB:`SARSEQ_MODE_REF_LSB];
    assign O_LADDER_CODE = sar_code;
    assign O_IRQ         = st_r.irq;
    assign O_RDATA       = st_r.rd_data;
    assign O_RD_VALID    = st_r.rd_valid;
    assign O_WAIT        = st_r.rd_wait;

    // ****************************************
    // Checks
    // ****************************************
    // Cycles since sampling began, for the conversion-time check
    logic [8:0] conv_len_r;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            conv_len_r <= 9'h000;
        end else if (O_SAMPLE && !$past(O_SAMPLE)) begin
            conv_len_r <= 9'h001;
        end else begin
            conv_len_r <= 9'(conv_len_r + 9'h001);
        end
    end

    sequence s_result_read;
        I_RD && !O_WAIT && is_result(I_ADDR);
    endsequence
    sequence s_wait_then_data;
        O_WAIT && !O_RD_VALID ##1 O_RD_VALID && !O_WAIT;
    endsequence

    chk_irq_cause: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_IRQ |-> $past(sar_done) && $past(run)) else $error("interrupt without completion");
    chk_irq_pulse: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_IRQ |=> !O_IRQ) else $error("interrupt longer than one cycle");
    chk_result_copy: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        sar_done && run |=> st_r.result == $past(sar_code)) else $error("result not transferred");
    chk_hi_match: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_IRQ |-> st_r.result_hi == st_r.result[9:2]) else $error("high byte differs from word");
    chk_read_wait: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        s_result_read |=> s_wait_then_data) else $error("result read without one wait cycle");
    chk_word_align: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_RD_VALID && $past(O_WAIT) && !$past(st_r.rd_hi) |-> O_RDATA[5:0] == 6'h00
        && O_RDATA[15:6] == $past(st_r.result)) else $error("result word misaligned");
    chk_bit6_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (I_WR || I_BIT_WR) && I_ADDR == `SARSEQ_ADDR_MODE |=> !st_r.mode[`SARSEQ_MODE_FIXED0])
        else $error("fixed mode bit set");
    chk_abort_quiet: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !run |=> !O_IRQ && $stable(st_r.result)) else $error("stopped converter updated result");
    chk_stop_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !run ##1 !run |-> !O_SAMPLE && st_r.state != sarseq_pkg::ST_CONVERT)
        else $error("stopped converter still running");
    chk_hold_steady: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        $fell(O_SAMPLE) && run |-> !O_SAMPLE[*8]) else $error("sample taken during conversion");
    chk_conv_time: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        sar_done && run && $stable(tsel) |-> conv_len_r == conv_cycles(tsel))
        else $error("conversion length wrong for time code");
    // Mode register, sequencing and high-byte read checks
    chk_run_starts: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        run && (st_r.state == sarseq_pkg::ST_STOP || st_r.state == sarseq_pkg::ST_WAIT) |=> O_SAMPLE)
        else $error("run bit did not start sampling");
    chk_wait_mode: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !run && O_CMP_EN ##1 !run && O_CMP_EN |-> st_r.state == sarseq_pkg::ST_WAIT)
        else $error("comparator-only mode not waiting");
    chk_repeat_conv: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        sar_done && run |-> O_SAMPLE) else $error("conversion did not repeat");
    chk_hi_read: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_RD_VALID && $past(O_WAIT) && $past(st_r.rd_hi) |-> O_RDATA == {8'h00, $past(st_r.result_hi)})
        else $error("high byte read wrong");
    chk_bit_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_BIT_WR && !I_WR && I_ADDR == `SARSEQ_ADDR_MODE && I_BIT_POS != 3'(`SARSEQ_MODE_FIXED0)
        |=> st_r.mode[$past(I_BIT_POS)] == $past(I_BIT_VAL)) else $error("bit write to mode lost");
    chk_byte_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        I_WR && I_ADDR == `SARSEQ_ADDR_MODE |=> st_r.mode == ($past(I_WDATA) & 8'hBF))
        else $error("byte write to mode lost");
    chk_bit_step: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        sar_decide |-> st_r.step_cnt >= 4'(`SARSEQ_MIN_BIT_STEP - 4'h1))
        else $error("bit step shorter than synchroniser delay");
endmodule

// >>> sarseq_afe_model.sv
// Purpose: Far-side model: sample-and-hold, ladder and comparator.
// Assumes: Each channel carries a fixed level.
// Notes:   Unpowered comparator toggles, so it never gives a steady answer.
`timescale 1ns/1ps
module sarseq_afe_model (
    input  wire logic       i_clk,
    input  wire logic       i_sample,
    input  wire logic       i_cmp_en,
    input  wire logic [9:0] i_code,
    input  wire logic [3:0] i_ch,
    output logic            o_cmp
);
    logic [9:0] held_r = 10'h000;
    logic       junk_r = 1'b0;
    // Track while sampling, freeze while converting
    always @(posedge i_clk) begin
        if (i_sample) begin
            held_r <= 10'h2D3 ^ {i_ch, 6'h00};
        end
        junk_r <= ~junk_r;
    end
    // High keeps the trial bit
    assign o_cmp = i_cmp_en ? (held_r >= i_code) : junk_r;
endmodule

// >>> testbench.sv
// Purpose: Register-level tests of the converter sequencer.
// Assumes: Analog side from sarseq_afe_model.
// Notes:   Periods are counted between done pulses.
`timescale 1ns/1ps
`include "sarseq_map.svh"
module testbench;
    logic        I_CLK = 1'b0;
    logic        I_RSTN, I_WR, I_BIT_WR, I_BIT_VAL, I_RD;
    logic [15:0] I_ADDR;
    logic [2:0]  I_BIT_POS;
    logic [7:0]  I_WDATA;
    logic [15:0] O_RDATA, O_PIN_ANALOG;
    logic        O_RD_VALID, O_WAIT, O_CMP_EN, O_SAMPLE, O_IRQ, I_CMP;
    logic [9:0]  O_LADDER_CODE;
    logic [1:0]  O_REF_RANGE;
    logic [3:0]  O_CH_SEL;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;
    int          tbl[6] = '{264, 176, 132, 88, 66, 44};
    sarseq_top dut_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WR(I_WR),
        .I_BIT_WR(I_BIT_WR), .I_BIT_POS(I_BIT_POS), .I_BIT_VAL(I_BIT_VAL), .I_WDATA(I_WDATA),
        .I_RD(I_RD), .O_RDATA(O_RDATA), .O_RD_VALID(O_RD_VALID), .O_WAIT(O_WAIT), .I_CMP(I_CMP),
        .O_CMP_EN(O_CMP_EN), .O_SAMPLE(O_SAMPLE), .O_LADDER_CODE(O_LADDER_CODE),
        .O_REF_RANGE(O_REF_RANGE), .O_CH_SEL(O_CH_SEL), .O_PIN_ANALOG(O_PIN_ANALOG), .O_IRQ(O_IRQ));
    sarseq_afe_model afe_u (.i_clk(I_CLK), .i_sample(O_SAMPLE), .i_cmp_en(O_CMP_EN),
        .i_code(O_LADDER_CODE), .i_ch(O_CH_SEL), .o_cmp(I_CMP));
    // ****************************************
    // Clock, watchdog and helpers
    // ****************************************
    always #2.5 I_CLK = ~I_CLK;
    // Hang guard, well above the expected run
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    function automatic logic [9:0] lvl(input logic [3:0] ch);
        return 10'h2D3 ^ {ch, 6'h00};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge I_CLK);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        I_ADDR = a;
        I_WDATA = d;
        I_WR = 1'b1;
        step();
        I_WR = 1'b0;
        step();
    endtask
    task automatic bwr(input logic [2:0] p, input logic v);
        I_ADDR = `SARSEQ_ADDR_MODE;
        I_BIT_POS = p;
        I_BIT_VAL = v;
        I_BIT_WR = 1'b1;
        step();
        I_BIT_WR = 1'b0;
        step();
    endtask
    // Read, noting whether a wait cycle came first
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic ew);
        logic w;
        w = 1'b0;
        I_ADDR = a;
        I_RD = 1'b1;
        step();
        I_RD = 1'b0;
        for (int k = 0; k < 4 && O_RD_VALID !== 1'b1; k++) begin
            w = w | (O_WAIT === 1'b1);
            step();
        end
        chk({15'h0, w}, {15'h0, ew});
        chk(O_RDATA, exp);
        step();
    endtask
    task automatic wait_irq(output int cnt);
        cnt = 0;
        do begin
            step();
            cnt++;
        end while (O_IRQ !== 1'b1 && cnt < 600);
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {I_RSTN, I_WR, I_BIT_WR, I_BIT_VAL, I_RD, I_BIT_POS, I_WDATA, I_ADDR} = '0;
        repeat (5) @(posedge I_CLK);
        #1 I_RSTN = 1'b1;
        rd(`SARSEQ_ADDR_MODE, 16'h0000, 1'b0);
        rd(`SARSEQ_ADDR_PINCFG, 16'h0010, 1'b0);
        rd(16'hFF00, 16'h0000, 1'b0);
        chk(O_PIN_ANALOG, 16'hFFFF);
        $display("test reset done");
        wr(`SARSEQ_ADDR_MODE, 8'h7E);
        rd(`SARSEQ_ADDR_MODE, 16'h003E, 1'b0);
        chk({14'h0, O_REF_RANGE}, 16'h0003);
        bwr(3'h0, 1'b1);
        rd(`SARSEQ_ADDR_MODE, 16'h003F, 1'b0);
        chk({15'h0, O_CMP_EN}, 16'h0001);
        wr(`SARSEQ_ADDR_RESULT, 8'hFF);
        rd(`SARSEQ_ADDR_RESULT, 16'h0000, 1'b1);
        wr(`SARSEQ_ADDR_PINCFG, 8'h03);
        chk(O_PIN_ANALOG, 16'h0007);
        wr(`SARSEQ_ADDR_CHSEL, 8'h05);
        chk({12'h0, O_CH_SEL}, 16'h0005);
        $display("test registers done");
        for (int c = 0; c < 6; c++) begin
            bwr(3'h7, 1'b0);
            wr(`SARSEQ_ADDR_MODE, {2'b00, c[2:0], 3'b001});
            repeat (200) step();
            wr(`SARSEQ_ADDR_MODE, {2'b10, c[2:0], 3'b001});
            wait_irq(n);
            wait_irq(n);
            chk(16'(n), 16'(tbl[c]));
            step();
            chk({15'h0, O_IRQ}, 16'h0000);
        end
        rd(`SARSEQ_ADDR_RESULT, {lvl(4'h5), 6'h00}, 1'b1);
        rd(`SARSEQ_ADDR_RESULT_HI, {6'h00, lvl(4'h5) >> 2}, 1'b1);
        $display("test timing done");
        wait_irq(n);
        wr(`SARSEQ_ADDR_CHSEL, 8'h0A);
        bwr(3'h7, 1'b0);
        wait_irq(n);
        chk(16'(n), 16'd600);
        rd(`SARSEQ_ADDR_RESULT, {lvl(4'h5), 6'h00}, 1'b1);
        bwr(3'h7, 1'b1);
        wait_irq(n);
        wait_irq(n);
        rd(`SARSEQ_ADDR_RESULT_HI, {6'h00, lvl(4'hA) >> 2}, 1'b1);
        $display("test abort done");
        finish_test();
    end
endmodule
